// *** shared/cur_arb_pkg.sv ***
// Constants, register map and carrier types for the current-measure arbiter and filter
package cur_arb_pkg;
   localparam int unsigned NUM_CORES     = 4;
   localparam int unsigned NUM_BLOCKS    = 4;
   localparam int unsigned NUM_FB        = 6;
   localparam int unsigned LEN_W         = 5;
   localparam int unsigned GRANT_W       = 5;
   localparam int unsigned INVAL_W       = 7;
   localparam int unsigned ADDR_W        = 12;
   localparam int unsigned CFG_REGS      = 3;
   localparam int unsigned FIELD_W       = 6;
   localparam int unsigned TYPE_BIT      = 5;
   localparam int unsigned GB_BLOCK4_LOW = 3;
   localparam int unsigned GB_BLOCK4_HI  = 4;
   localparam int unsigned FB_HIGH       = 4;
   localparam int unsigned FB_NEG        = 5;

   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_GRANT1    = 10'h188;
   localparam logic [9:0] IDX_GRANT2    = 10'h189;
   localparam logic [9:0] IDX_FILT12    = 10'h198;
   localparam logic [9:0] IDX_FILT34L   = 10'h199;
   localparam logic [9:0] IDX_FILT4HN   = 10'h19a;

   localparam logic [9:0]  GRANT1_RESET = 10'h041;
   localparam logic [9:0]  GRANT2_RESET = 10'h304;
   localparam logic [11:0] FILT_RESET   = 12'h041;
   localparam logic [6:0]  SETTLE_PAD   = 7'h04;

   typedef struct packed {
      logic       dac_v;
      logic [7:0] dac;
      logic       gain_v;
      logic [1:0] gain;
      logic       ofs_v;
      logic       ofs;
   } ctrl_req_t;

   typedef struct packed {
      logic [7:0] dac;
      logic [1:0] gain;
      logic       ofs;
   } ctrl_t;

   typedef struct packed {
      logic       high_v;
      logic [7:0] high;
      logic       neg_v;
      logic [7:0] neg;
   } hi_req_t;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic              read;
      logic              write;
      logic [31:0]       writedata;
      logic [3:0]        byteenable;
   } avm_req_t;

   typedef enum logic {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_t;
endpackage : cur_arb_pkg

// *** hw/current_measure_arbiter_filter.sv ***
// Current-measure control arbiter with feedback debounce filters and register slave
`timescale 1ns/1ps
`default_nettype none
module current_measure_arbiter_filter
   import cur_arb_pkg::*;
#(
   parameter int unsigned DAC_SETTLE_CYCLES = 4
) (
   input  wire logic      mclk,
   input  wire logic      resetn,
   input  wire avm_req_t  av_req,
   output logic           av_waitrequest,
   output logic [31:0]    av_readdata,
   input  wire ctrl_req_t core_req [NUM_CORES][NUM_BLOCKS],
   input  wire hi_req_t   core_hi_req [NUM_CORES],
   output ctrl_t          block_ctrl [NUM_BLOCKS],
   output logic [7:0]     dac4_high,
   output logic [7:0]     dac4_neg,
   input  wire logic [NUM_FB-1:0] fb_raw,
   output logic [NUM_FB-1:0]      fb_filtered,
   output logic [NUM_FB-1:0]      fb_valid
);

   if (DAC_SETTLE_CYCLES > 31) begin : g_bad_settle
      $error("DAC_SETTLE_CYCLES must fit five bits");
   end

   localparam logic [4:0] SETTLE = 5'(DAC_SETTLE_CYCLES);

   function automatic logic [1:0] first_set(input logic [NUM_CORES-1:0] v);
      logic [1:0] idx;
      idx = 2'h0;
      for (int i = NUM_CORES - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction : first_set

   function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                              input logic [3:0] be);
      logic [15:0] r;
      r = old_v;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction : lane_merge

   bus_state_t       state_ff;
   logic [9:0]       grant1_ff;
   logic [9:0]       grant2_ff;
   logic [11:0]      filt_cfg_ff [CFG_REGS];
   logic [31:0]      rdata_ff;
   logic [31:0]      nxt_rdata;
   logic             bus_req;
   logic             addr_ok;
   logic [9:0]       reg_idx;
   logic             wr_take;

   assign bus_req        = av_req.read | av_req.write;
   assign reg_idx        = av_req.address[ADDR_W-1:2];
   assign addr_ok        = (av_req.address[1:0] == 2'h0);
   assign av_waitrequest = bus_req & (state_ff == BUS_IDLE);
   assign av_readdata    = rdata_ff;
   assign wr_take        = av_req.write & (state_ff == BUS_ANSWER);

   // One wait cycle: read data are latched while waitrequest is high
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= BUS_IDLE;
      end else begin
         unique case (state_ff)
            BUS_IDLE:   state_ff <= bus_req ? BUS_ANSWER : BUS_IDLE;
            BUS_ANSWER: state_ff <= BUS_IDLE;
         endcase
      end
   end

   always_comb begin
      nxt_rdata = 32'h0;
      if (addr_ok) begin
         unique case (reg_idx)
            IDX_GRANT1:  nxt_rdata = {22'h0, grant1_ff};
            IDX_GRANT2:  nxt_rdata = {22'h0, grant2_ff};
            IDX_FILT12:  nxt_rdata = {20'h0, filt_cfg_ff[0]};
            IDX_FILT34L: nxt_rdata = {20'h0, filt_cfg_ff[1]};
            IDX_FILT4HN: nxt_rdata = {20'h0, filt_cfg_ff[2]};
            default:     nxt_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= 32'h0;
      end else if (av_req.read && state_ff == BUS_IDLE) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Unmapped or misaligned writes are dropped
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         grant1_ff <= GRANT1_RESET;
         grant2_ff <= GRANT2_RESET;
         for (int i = 0; i < CFG_REGS; i++) begin
            filt_cfg_ff[i] <= FILT_RESET;
         end
      end else if (wr_take && addr_ok) begin
         unique case (reg_idx)
            IDX_GRANT1:  grant1_ff <= 10'(lane_merge({6'h0, grant1_ff}, av_req.writedata,
                                                     av_req.byteenable));
            IDX_GRANT2:  grant2_ff <= 10'(lane_merge({6'h0, grant2_ff}, av_req.writedata,
                                                     av_req.byteenable));
            IDX_FILT12:  filt_cfg_ff[0] <= 12'(lane_merge({4'h0, filt_cfg_ff[0]},
                                                          av_req.writedata, av_req.byteenable));
            IDX_FILT34L: filt_cfg_ff[1] <= 12'(lane_merge({4'h0, filt_cfg_ff[1]},
                                                          av_req.writedata, av_req.byteenable));
            IDX_FILT4HN: filt_cfg_ff[2] <= 12'(lane_merge({4'h0, filt_cfg_ff[2]},
                                                          av_req.writedata, av_req.byteenable));
            default: ;
         endcase
      end
   end

   // Grant per core in priority order
   logic [GRANT_W-1:0] grant [NUM_CORES];
   assign grant[0] = grant1_ff[GRANT_W-1:0];
   assign grant[1] = grant1_ff[2*GRANT_W-1:GRANT_W];
   assign grant[2] = grant2_ff[GRANT_W-1:0];
   assign grant[3] = grant2_ff[2*GRANT_W-1:GRANT_W];

   ctrl_t                ctrl_ff [NUM_BLOCKS];
   ctrl_t                nxt_ctrl [NUM_BLOCKS];
   logic [7:0]           high_ff;
   logic [7:0]           neg_ff;
   logic [7:0]           nxt_high;
   logic [7:0]           nxt_neg;
   logic [NUM_CORES-1:0] dac_win [NUM_BLOCKS];
   logic [NUM_CORES-1:0] gain_win [NUM_BLOCKS];
   logic [NUM_CORES-1:0] ofs_win [NUM_BLOCKS];
   logic [NUM_CORES-1:0] high_win;
   logic [NUM_CORES-1:0] neg_win;
   logic [NUM_FB-1:0]    dac_wr;

   always_comb begin
      for (int b = 0; b < NUM_BLOCKS; b++) begin
         nxt_ctrl[b] = ctrl_ff[b];
         for (int c = 0; c < NUM_CORES; c++) begin
            dac_win[b][c]  = core_req[c][b].dac_v & grant[c][b];
            gain_win[b][c] = core_req[c][b].gain_v & grant[c][b];
            ofs_win[b][c]  = core_req[c][b].ofs_v & grant[c][b];
         end
         // Each cycle's winner is applied at once, so requests spaced apart all land
         if (|dac_win[b]) begin
            nxt_ctrl[b].dac = core_req[first_set(dac_win[b])][b].dac;
         end
         if (|gain_win[b]) begin
            nxt_ctrl[b].gain = core_req[first_set(gain_win[b])][b].gain;
         end
         if (|ofs_win[b]) begin
            nxt_ctrl[b].ofs = core_req[first_set(ofs_win[b])][b].ofs;
         end
         dac_wr[b] = |dac_win[b];
      end
      for (int c = 0; c < NUM_CORES; c++) begin
         high_win[c] = core_hi_req[c].high_v & grant[c][GB_BLOCK4_HI];
         neg_win[c]  = core_hi_req[c].neg_v & grant[c][GB_BLOCK4_HI];
      end
      nxt_high = (|high_win) ? core_hi_req[first_set(high_win)].high : high_ff;
      nxt_neg  = (|neg_win) ? core_hi_req[first_set(neg_win)].neg : neg_ff;
      dac_wr[FB_HIGH] = |high_win;
      dac_wr[FB_NEG]  = |neg_win;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int b = 0; b < NUM_BLOCKS; b++) begin
            ctrl_ff[b] <= '0;
         end
         high_ff <= 8'h0;
         neg_ff  <= 8'h0;
      end else begin
         ctrl_ff  <= nxt_ctrl;
         high_ff  <= nxt_high;
         neg_ff   <= nxt_neg;
      end
   end

   assign block_ctrl = ctrl_ff;
   assign dac4_high  = high_ff;
   assign dac4_neg   = neg_ff;

   // Feedback filters, one counter each
   logic [LEN_W-1:0]   flen [NUM_FB];
   logic [NUM_FB-1:0]  ftype;
   logic [LEN_W:0]     cnt_ff [NUM_FB];
   logic [NUM_FB-1:0]  filt_ff;
   logic [INVAL_W-1:0] inval_ff [NUM_FB];

   for (genvar k = 0; k < NUM_FB; k++) begin : g_filt
      localparam int unsigned R = k / 2;
      localparam int unsigned L = (k % 2) * FIELD_W;
      assign flen[k]  = filt_cfg_ff[R][L +: LEN_W];
      assign ftype[k] = filt_cfg_ff[R][L + TYPE_BIT];

      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            cnt_ff[k]  <= '0;
            filt_ff[k] <= 1'b0;
         end else if (fb_raw[k] != filt_ff[k]) begin
            // Level must be seen length plus one times before it is taken
            if (cnt_ff[k] == {1'b0, flen[k]}) begin
               filt_ff[k] <= fb_raw[k];
               cnt_ff[k]  <= '0;
            end else begin
               cnt_ff[k] <= cnt_ff[k] + 6'h01;
            end
         end else if (!ftype[k]) begin
            cnt_ff[k] <= '0;
         end else if (cnt_ff[k] != '0) begin
            cnt_ff[k] <= cnt_ff[k] - 6'h01;
         end
      end

      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            inval_ff[k] <= '0;
         end else if (dac_wr[k]) begin
            inval_ff[k] <= {2'h0, SETTLE} + {2'h0, flen[k]} + SETTLE_PAD;
         end else if (inval_ff[k] != '0) begin
            inval_ff[k] <= inval_ff[k] - 7'h01;
         end
      end

      assign fb_valid[k] = (inval_ff[k] == '0);
   end

   assign fb_filtered = filt_ff;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   property p_top_priority;
      dac_win[0][0] |=> block_ctrl[0].dac == $past(core_req[0][0].dac);
   endproperty
   a_top_priority: assert property (p_top_priority) else $error("c0ch1 not chosen");

   property p_second_priority;
      (dac_win[1] == 4'b0110) |=> block_ctrl[1].dac == $past(core_req[1][1].dac);
   endproperty
   a_second_priority: assert property (p_second_priority) else $error("bad order");

   sequence s_lone_low;
      dac_win[2] == 4'b1000;
   endsequence
   property p_each_applied;
      s_lone_low ##1 s_lone_low |=> block_ctrl[2].dac == $past(core_req[3][2].dac);
   endproperty
   a_each_applied: assert property (p_each_applied) else $error("change lost");

   property p_refused;
      (dac_win[0] == 4'b0000) |=> $stable(block_ctrl[0].dac);
   endproperty
   a_refused: assert property (p_refused) else $error("ungranted change");

   property p_block4_hi;
      (core_hi_req[0].high_v && !grant[0][GB_BLOCK4_HI] && high_win == 4'b0000)
         |=> $stable(dac4_high);
   endproperty
   a_block4_hi: assert property (p_block4_hi) else $error("high DAC grant ignored");

   property p_clear;
      (!ftype[0] && fb_raw[0] == filt_ff[0]) |=> cnt_ff[0] == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("counter not cleared");

   property p_decr;
      (ftype[1] && fb_raw[1] == filt_ff[1] && cnt_ff[1] != '0 && $stable(ftype[1]))
         |=> cnt_ff[1] == $past(cnt_ff[1]) - 6'h01;
   endproperty
   a_decr: assert property (p_decr) else $error("counter not decremented");

   property p_flip_cause;
      $changed(filt_ff[2]) |-> $past(cnt_ff[2]) == {1'b0, $past(flen[2])};
   endproperty
   a_flip_cause: assert property (p_flip_cause) else $error("early flip");

   property p_flip_time;
      (fb_raw[3] != filt_ff[3] && cnt_ff[3] == {1'b0, flen[3]}) |=> filt_ff[3] == $past(fb_raw[3]);
   endproperty
   a_flip_time: assert property (p_flip_time) else $error("late flip");

   property p_invalid;
      dac_wr[0] |=> !fb_valid[0] && inval_ff[0] == {2'h0, SETTLE} + {2'h0, $past(flen[0])}
                    + SETTLE_PAD;
   endproperty
   a_invalid: assert property (p_invalid) else $error("feedback not invalidated");

endmodule : current_measure_arbiter_filter
`default_nettype wire

// *** bench/cores_model.sv ***
// Behavioural model of the four sequencer cores
`timescale 1ns/1ps
`default_nettype none
module cores_model
   import cur_arb_pkg::*;
(
   output var ctrl_req_t core_req [NUM_CORES][NUM_BLOCKS],
   output var hi_req_t   core_hi_req [NUM_CORES]
);
   initial begin
      for (int c = 0; c < NUM_CORES; c++) begin
         for (int b = 0; b < NUM_BLOCKS; b++) core_req[c][b] = '0;
         core_hi_req[c] = '0;
      end
   end

   // Idle data inverted so a stale value never looks valid
   task automatic set_dac(input logic [3:0] m, input int blk, input logic [7:0] base);
      for (int c = 0; c < NUM_CORES; c++) begin
         core_req[c][blk].dac_v <= m[c];
         core_req[c][blk].dac   <= m[c] ? base + 8'(c) : ~(base + 8'(c));
      end
   endtask : set_dac

   task automatic set_gain(input logic [3:0] m, input int blk);
      for (int c = 0; c < NUM_CORES; c++) begin
         core_req[c][blk].gain_v <= m[c];
         core_req[c][blk].gain   <= 2'(c);
         core_req[c][blk].ofs_v  <= m[c];
         core_req[c][blk].ofs    <= 1'(c);
      end
   endtask : set_gain

   task automatic set_hi(input logic [3:0] m, input logic [7:0] base);
      for (int c = 0; c < NUM_CORES; c++) begin
         core_hi_req[c].high_v <= m[c];
         core_hi_req[c].high   <= base + 8'(c);
         core_hi_req[c].neg_v  <= m[c];
         core_hi_req[c].neg    <= base + 8'(c) + 8'h80;
      end
   endtask : set_hi
endmodule : cores_model
`default_nettype wire

// *** bench/current_measure_arbiter_filter_tb.sv ***
// Self-checking bench for the current-measure arbiter and filter
`timescale 1ns/1ps
`default_nettype none
module current_measure_arbiter_filter_tb
   import cur_arb_pkg::*;
#(parameter int unsigned SETTLE = 3);
   logic              mclk = 1'b0;
   logic              resetn = 1'b0;
   avm_req_t          av_req = '0;
   logic              av_waitrequest;
   logic [31:0]       av_readdata;
   ctrl_req_t         core_req [NUM_CORES][NUM_BLOCKS];
   hi_req_t           core_hi_req [NUM_CORES];
   ctrl_t             block_ctrl [NUM_BLOCKS];
   logic [7:0]        dac4_high;
   logic [7:0]        dac4_neg;
   logic [NUM_FB-1:0] fb_raw = '0;
   logic [NUM_FB-1:0] fb_filtered;
   logic [NUM_FB-1:0] fb_valid;
   int                fails = 0;
   int                samples_checked = 0;
   int                cnt;
   logic [31:0]       rd;

   always #20 mclk = ~mclk;

   current_measure_arbiter_filter #(.DAC_SETTLE_CYCLES(SETTLE)) u_current_measure_arbiter_filter (
      .mclk(mclk), .resetn(resetn), .av_req(av_req), .av_waitrequest(av_waitrequest),
      .av_readdata(av_readdata), .core_req(core_req), .core_hi_req(core_hi_req),
      .block_ctrl(block_ctrl), .dac4_high(dac4_high), .dac4_neg(dac4_neg),
      .fb_raw(fb_raw), .fb_filtered(fb_filtered), .fb_valid(fb_valid));

   cores_model u_cores_model (.core_req(core_req), .core_hi_req(core_hi_req));

   task automatic final_report();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge mclk);
      av_req <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hf};
      do begin
         @(posedge mclk);
         n++;
      end while (av_waitrequest !== 1'b0 && n < 20);
      rd = av_readdata;
      av_req.read  <= 1'b0;
      av_req.write <= 1'b0;
      if (av_waitrequest !== 1'b0) begin
         fails++;
         final_report();
      end
   endtask : bus

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask : rdchk

   // Holds the raw levels for n sampling edges, then looks at the filters
   task automatic fb_step(input logic [5:0] v, input int n, input logic [5:0] exp);
      fb_raw <= v;
      repeat (n) @(posedge mclk);
      #1;
      chk("fb_filtered", exp, fb_filtered);
   endtask : fb_step

   task automatic dac_step(input logic [3:0] m, input int blk, input logic [7:0] base);
      u_cores_model.set_dac(m, blk, base);
      @(posedge mclk);
      #1;
   endtask : dac_step

   task automatic t_regs();
      rdchk("grant1", {IDX_GRANT1, 2'b00}, 32'(GRANT1_RESET));
      rdchk("grant2", {IDX_GRANT2, 2'b00}, 32'(GRANT2_RESET));
      rdchk("filt12", {IDX_FILT12, 2'b00}, 32'(FILT_RESET));
      rdchk("filt34", {IDX_FILT34L, 2'b00}, 32'(FILT_RESET));
      rdchk("filt4hn", {IDX_FILT4HN, 2'b00}, 32'(FILT_RESET));
      rdchk("unmapped", 12'h600, 32'h0);
      bus(1'b1, {IDX_GRANT1, 2'b00}, 32'hffff_ffff);
      rdchk("grant1_rsvd", {IDX_GRANT1, 2'b00}, 32'h3ff);
      $display("test regs done");
   endtask : t_regs

   task automatic t_filter();
      bus(1'b1, {IDX_FILT12, 2'b00}, 32'h043);
      rdchk("filt12", {IDX_FILT12, 2'b00}, 32'h043);
      fb_step(6'h03, 3, 6'h02);
      fb_step(6'h02, 1, 6'h02);
      fb_step(6'h03, 3, 6'h02);
      fb_step(6'h03, 1, 6'h03);
      bus(1'b1, {IDX_FILT12, 2'b00}, 32'h063);
      fb_step(6'h02, 3, 6'h03);
      fb_step(6'h03, 1, 6'h03);
      fb_step(6'h02, 1, 6'h03);
      fb_step(6'h02, 1, 6'h02);
      fb_step(6'h0e, 2, 6'h0e);
      $display("test filter done");
   endtask : t_filter

   task automatic t_prio();
      bus(1'b1, {IDX_GRANT2, 2'b00}, 32'h3ff);
      // Back-to-back cycles, winner drops one place each time
      for (int k = 0; k < 4; k++) begin
         dac_step(4'(4'hf << k), 0, 8'(16 * k + 16));
         chk("prio", 16 * k + 16 + k, block_ctrl[0].dac);
      end
      bus(1'b1, {IDX_GRANT1, 2'b00}, 32'h3fe);
      dac_step(4'b1001, 0, 8'h50);
      chk("ungranted", 32'h53, block_ctrl[0].dac);
      dac_step(4'b0001, 0, 8'h60);
      chk("refused", 32'h53, block_ctrl[0].dac);
      dac_step(4'b0100, 1, 8'h70);
      chk("seq_a", 32'h72, block_ctrl[1].dac);
      dac_step(4'b0010, 1, 8'h80);
      chk("seq_b", 32'h81, block_ctrl[1].dac);
      u_cores_model.set_gain(4'b0110, 2);
      @(posedge mclk);
      #1;
      u_cores_model.set_gain(4'h0, 2);
      chk("gain", 32'h1, block_ctrl[2].gain);
      chk("ofs", 32'h1, block_ctrl[2].ofs);
      u_cores_model.set_dac(4'h0, 1, 8'h0);
      $display("test prio done");
   endtask : t_prio

   task automatic t_invalid();
      cnt = 0;
      while (fb_valid[0] !== 1'b1 && cnt < 100) begin
         @(posedge mclk);
         cnt++;
      end
      if (fb_valid[0] !== 1'b1) begin
         fails++;
         final_report();
      end
      dac_step(4'b0010, 0, 8'h33);
      u_cores_model.set_dac(4'h0, 0, 8'h0);
      cnt = 0;
      for (int i = 0; i < 40; i++) begin
         if (fb_valid[0] === 1'b0) cnt++;
         @(posedge mclk);
         #1;
      end
      chk("invalid_cycles", SETTLE + 3 + 4, cnt);
      $display("test invalid done");
   endtask : t_invalid

   task automatic t_block4();
      bus(1'b1, {IDX_GRANT1, 2'b00}, 32'h008);
      bus(1'b1, {IDX_GRANT2, 2'b00}, 32'h000);
      u_cores_model.set_hi(4'h1, 8'h11);
      dac_step(4'h1, 3, 8'h22);
      u_cores_model.set_hi(4'h0, 8'h0);
      u_cores_model.set_dac(4'h0, 3, 8'h0);
      chk("hi_refused", 32'h0, dac4_high);
      chk("low_taken", 32'h22, block_ctrl[3].dac);
      bus(1'b1, {IDX_GRANT1, 2'b00}, 32'h010);
      u_cores_model.set_hi(4'h1, 8'h11);
      dac_step(4'h1, 3, 8'h44);
      u_cores_model.set_hi(4'h0, 8'h0);
      u_cores_model.set_dac(4'h0, 3, 8'h0);
      chk("hi_taken", 32'h11, dac4_high);
      chk("neg_taken", 32'h91, dac4_neg);
      chk("low_refused", 32'h22, block_ctrl[3].dac);
      $display("test block4 done");
   endtask : t_block4

   initial begin
      repeat (6) @(posedge mclk);
      chk("valid_rst", 32'h3f, fb_valid);
      resetn <= 1'b1;
      t_regs();
      t_filter();
      t_prio();
      t_invalid();
      t_block4();
      final_report();
   end
endmodule : current_measure_arbiter_filter_tb
`default_nettype wire
